// [src/sdc_defines.svh]
// Register map, field positions, reset values and divider constants of the converter slice
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// Register indices; byte address is four times the index
`define SDC_IDX_RESULT_LOW   8'h04
`define SDC_IDX_RESULT_MID   8'h05
`define SDC_IDX_RESULT_HIGH  8'h06
`define SDC_IDX_CTRL_ONE     8'h08
`define SDC_IDX_SRC_DIV      8'h09
`define SDC_IDX_TRIM         8'h0a
`define SDC_IDX_OSR_SEL      8'h10
`define SDC_IDX_IRQ_STATUS   8'h11
`define SDC_IDX_IRQ_MASK     8'h12

// Control one fields
`define SDC_CTRL_MODSEL_LSB  5
`define SDC_CTRL_NEGBUF_BIT  4
`define SDC_CTRL_POSBUF_BIT  3
`define SDC_CTRL_HOLD_BIT    2
`define SDC_CTRL_EOC_BIT     1

// Reset values
`define SDC_CTRL_ONE_RST     8'h00
`define SDC_SRC_DIV_RST      5'h00
`define SDC_TRIM_RST         8'he4
`define SDC_OSR_SEL_RST      4'h4
`define SDC_IRQ_MASK_RST     2'h0

// Interrupt status bits
`define SDC_IRQ_DONE_BIT     0
`define SDC_IRQ_DROP_BIT     1

// Modulator divider codes and ratios
`define SDC_MODSEL_N30       3'h0
`define SDC_MODSEL_N12       3'h2
`define SDC_MOD_RATIO_30     5'd30
`define SDC_MOD_RATIO_12     5'd12

// Source divider pass-through code
`define SDC_SRC_PASS_CODE    5'h1f

// Oversampling select codes
`define SDC_OSR_CODE_16384   4'h1
`define SDC_OSR_CODE_2048    4'h4
`define SDC_OSR_CODE_512     4'h6

`endif

// [src/sdc_pkg.sv]
// Types shared by the converter slice modules
package sdc_pkg;

    // Source divider state
    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } sdc_src_state_t;

    // Modulator divider state
    typedef struct packed {
        logic [4:0] cnt;
        logic       tick;
    } sdc_mod_state_t;

    // Phase of the oversampling sequence
    typedef enum logic [0:0] {
        SDC_PH_RUN  = 1'b0,
        SDC_PH_DONE = 1'b1
    } sdc_phase_t;

    // Top-level state
    typedef struct packed {
        logic [2:0]  modsel;
        logic        negbuf;
        logic        posbuf;
        logic        hold;
        logic        eoc;
        logic [4:0]  srcdiv;
        logic [7:0]  trim;
        logic [3:0]  osrsel;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [23:0] result;
        logic [14:0] osr_cnt;
        sdc_phase_t  phase;
        logic        conv_done;
        logic        irq;
        logic        negbyp;
        logic        posbyp;
        logic        ack;
        logic [31:0] rdata;
    } sdc_state_t;

endpackage

// [src/sdc_src_div.sv]
// Source clock divider producing master clock enable pulses
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_src_div
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [4:0] div_sel_i,
    output logic            tick_o
);
    import sdc_pkg::*;

    sdc_src_state_t s_q;
    sdc_src_state_t s_d;
    logic [5:0]     last;

    // Period is 2*(code+1) source cycles, one cycle for the pass code; enable instead of a derived clock net
    always_comb
    begin
        s_d  = s_q;
        last = {div_sel_i, 1'b1};
        if (div_sel_i == `SDC_SRC_PASS_CODE)
        begin
            s_d.cnt  = 6'h00;
            s_d.tick = 1'b1;
        end
        else if (s_q.cnt >= last)
        begin
            s_d.cnt  = 6'h00;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt  = s_q.cnt + 6'h01;
            s_d.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tick_o = s_q.tick;
endmodule // sdc_src_div

// [src/sdc_mod_div.sv]
// Modulator divider counting master clock enables down to the modulator clock
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_mod_div
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    import sdc_pkg::*;

    sdc_mod_state_t s_q;
    sdc_mod_state_t s_d;
    logic [4:0]     ratio;

    // Reserved codes keep the 30 ratio so the filter never starves
    always_comb
    begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (sel_i == `SDC_MODSEL_N12)
            ratio = `SDC_MOD_RATIO_12;
        else
            ratio = `SDC_MOD_RATIO_30;
        if (tick_i)
        begin
            if (s_q.cnt >= ratio - 5'd1)
            begin
                s_d.cnt  = 5'd0;
                s_d.tick = 1'b1;
            end
            else
                s_d.cnt = s_q.cnt + 5'd1;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tick_o = s_q.tick;
endmodule // sdc_mod_div

// [src/sdc_top.sv]
// Clock, result hold and status control of the delta-sigma converter with a Wishbone slave
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_top
#(
    parameter logic [14:0] OSR_16384 = 15'd16384,
    parameter logic [14:0] OSR_2048  = 15'd2048,
    parameter logic [14:0] OSR_512   = 15'd512
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [23:0] filter_result_i,
    output logic             master_clk_en_o,
    output logic             modulator_clk_en_o,
    output logic             conv_done_o,
    output logic [3:0]       oversampling_select_o,
    output logic             neg_ref_buffer_enable_o,
    output logic             neg_ref_bypass_o,
    output logic             pos_ref_buffer_enable_o,
    output logic             pos_ref_bypass_o,
    output logic [7:0]       reserved_trim_o,
    output logic             irq_o
);
    import sdc_pkg::*;

    sdc_state_t s_q;
    sdc_state_t s_d;
    logic       mclk_tick;
    logic       modclk_tick;
    logic       access;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] idx;
    logic [7:0] rbyte;
    logic [14:0] osr_last;
    logic       done_evt;

    // Oversampling code to ratio; reserved codes fall back to 2048
    function automatic logic [14:0] osr_ratio(input logic [3:0] code);
        logic [14:0] r;
        r = OSR_2048;
        if (code == `SDC_OSR_CODE_16384)
            r = OSR_16384;
        else if (code == `SDC_OSR_CODE_2048)
            r = OSR_2048;
        else if (code == `SDC_OSR_CODE_512)
            r = OSR_512;
        return r;
    endfunction

    // Master clock enable from the source clock
    sdc_src_div u_src_div
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .div_sel_i (s_q.srcdiv),
        .tick_o    (mclk_tick)
    );

    // Modulator clock enable from the master clock enable
    sdc_mod_div u_mod_div
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_i (mclk_tick),
        .sel_i  (s_q.modsel),
        .tick_o (modclk_tick)
    );

    // Bus access decode; effect lands on the edge that raises ack
    assign access   = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wr_en    = access & wb_we_i & wb_sel_i[0];
    assign rd_en    = access & ~wb_we_i;
    assign idx      = wb_adr_i[9:2];
    assign osr_last = osr_ratio(s_q.osrsel) - 15'd1;
    assign done_evt = modclk_tick && (s_q.osr_cnt >= osr_last);

    // Read multiplexer; unmapped indices read zero
    always_comb
    begin
        rbyte = 8'h00;
        if (idx == `SDC_IDX_RESULT_LOW)
            rbyte = s_q.result[7:0];
        else if (idx == `SDC_IDX_RESULT_MID)
            rbyte = s_q.result[15:8];
        else if (idx == `SDC_IDX_RESULT_HIGH)
            rbyte = s_q.result[23:16];
        else if (idx == `SDC_IDX_CTRL_ONE)
            rbyte = {s_q.modsel, s_q.negbuf, s_q.posbuf, s_q.hold, s_q.eoc, 1'b0};
        else if (idx == `SDC_IDX_SRC_DIV)
            rbyte = {3'h0, s_q.srcdiv};
        else if (idx == `SDC_IDX_TRIM)
            rbyte = s_q.trim;
        else if (idx == `SDC_IDX_OSR_SEL)
            rbyte = {4'h0, s_q.osrsel};
        else if (idx == `SDC_IDX_IRQ_STATUS)
            rbyte = {6'h00, s_q.irq_stat};
        else if (idx == `SDC_IDX_IRQ_MASK)
            rbyte = {6'h00, s_q.irq_mask};
    end

    // Next-state logic for registers, sequencing and interrupts
    always_comb
    begin
        s_d           = s_q;
        s_d.ack       = access;
        s_d.rdata     = rd_en ? {24'h000000, rbyte} : 32'h00000000;
        s_d.conv_done = 1'b0;

        // Register writes
        if (wr_en)
        begin
            if (idx == `SDC_IDX_CTRL_ONE)
            begin
                s_d.modsel = wb_dat_i[`SDC_CTRL_MODSEL_LSB +: 3];
                s_d.negbuf = wb_dat_i[`SDC_CTRL_NEGBUF_BIT];
                s_d.posbuf = wb_dat_i[`SDC_CTRL_POSBUF_BIT];
                s_d.hold   = wb_dat_i[`SDC_CTRL_HOLD_BIT];
                s_d.eoc    = wb_dat_i[`SDC_CTRL_EOC_BIT];
            end
            else if (idx == `SDC_IDX_SRC_DIV)
                s_d.srcdiv = wb_dat_i[4:0];
            else if (idx == `SDC_IDX_TRIM)
                s_d.trim = wb_dat_i[7:0];
            else if (idx == `SDC_IDX_OSR_SEL)
                s_d.osrsel = wb_dat_i[3:0];
            else if (idx == `SDC_IDX_IRQ_MASK)
                s_d.irq_mask = wb_dat_i[1:0];
        end

        // Status is cleared by reading it; new events below still win
        if (rd_en && idx == `SDC_IDX_IRQ_STATUS)
            s_d.irq_stat = 2'h0;

        // Oversampling counter runs on modulator enables, hold or not
        if (modclk_tick)
        begin
            if (done_evt)
            begin
                s_d.osr_cnt = 15'd0;
                s_d.phase   = SDC_PH_DONE;
            end
            else
            begin
                s_d.osr_cnt = s_q.osr_cnt + 15'd1;
                s_d.phase   = SDC_PH_RUN;
            end
        end

        // End of conversion: flag set wins over a software clear
        if (done_evt)
        begin
            s_d.conv_done                  = 1'b1;
            s_d.eoc                        = 1'b1;
            s_d.irq_stat[`SDC_IRQ_DONE_BIT] = 1'b1;
            if (s_q.hold)
                s_d.irq_stat[`SDC_IRQ_DROP_BIT] = 1'b1;
            else
                s_d.result = filter_result_i;
        end

        // Buffer enables and complementary bypass controls
        s_d.negbyp = ~s_d.negbuf;
        s_d.posbyp = ~s_d.posbuf;
        s_d.irq    = |(s_d.irq_stat & s_d.irq_mask);
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q          <= '0;
            s_q.trim     <= `SDC_TRIM_RST;
            s_q.srcdiv   <= `SDC_SRC_DIV_RST;
            s_q.osrsel   <= `SDC_OSR_SEL_RST;
            s_q.irq_mask <= `SDC_IRQ_MASK_RST;
            s_q.phase    <= SDC_PH_RUN;
            s_q.negbyp   <= 1'b1;
            s_q.posbyp   <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // Outputs come straight from flops
    assign wb_dat_o                = s_q.rdata;
    assign wb_ack_o                = s_q.ack;
    assign master_clk_en_o         = mclk_tick;
    assign modulator_clk_en_o      = modclk_tick;
    assign conv_done_o             = s_q.conv_done;
    assign oversampling_select_o   = s_q.osrsel;
    assign neg_ref_buffer_enable_o = s_q.negbuf;
    assign neg_ref_bypass_o        = s_q.negbyp;
    assign pos_ref_buffer_enable_o = s_q.posbuf;
    assign pos_ref_bypass_o        = s_q.posbyp;
    assign reserved_trim_o         = s_q.trim;
    assign irq_o                   = s_q.irq;
endmodule // sdc_top

// [verification/sdc_top_assertions.sv]
// Checker of bus, reference buffer, conversion and interrupt behaviour
`timescale 1ns/1ps
module sdc_top_assertions
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        conv_done_o,
    input wire logic        modulator_clk_en_o,
    input wire logic        neg_ref_buffer_enable_o,
    input wire logic        neg_ref_bypass_o,
    input wire logic        pos_ref_buffer_enable_o,
    input wire logic        pos_ref_bypass_o,
    input wire logic        irq_o
);
    // Single clock domain, so one clock and one reset for all
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_latency_a: assert property ($rose(wb_stb_i) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    neg_bypass_a: assert property (neg_ref_bypass_o == !neg_ref_buffer_enable_o)
        else $error("negative bypass not inverse of enable");
    pos_bypass_a: assert property (pos_ref_bypass_o == !pos_ref_buffer_enable_o)
        else $error("positive bypass not inverse of enable");
    done_pulse_a: assert property (conv_done_o |=> !conv_done_o)
        else $error("done longer than one cycle");
    done_on_mod_a: assert property (conv_done_o |-> modulator_clk_en_o
        || $past(modulator_clk_en_o))
        else $error("done without modulator pulse");
    irq_cause_a: assert property ($rose(irq_o) |-> conv_done_o || (wb_ack_o && wb_we_i))
        else $error("interrupt rose without cause");
endmodule // sdc_top_assertions

bind sdc_top sdc_top_assertions u_sdc_top_assertions (.*);

// [verification/tb_sdc_top.sv]
// Register and conversion tests of the converter slice top
`timescale 1ns/1ps
`include "sdc_defines.svh"
module tb_sdc_top;
    import sdc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [9:0]  adr   = 10'h0;
    logic [31:0] dat   = 32'h0;
    logic [23:0] res   = 24'h123456;
    logic [31:0] rd;
    logic [7:0]  rdv;
    logic [3:0]  osr;
    logic [7:0]  trim;
    logic        ack, mclk, mdc, done, nbe, nby, pbe, pby, irq;
    int          n_fail = 0;
    int          n_tests = 0;
    int          p;
    wire  [2:0]  pl = {done, mdc, mclk};

    // Short ratios make a conversion 8, 4 or 2 modulator periods long
    sdc_top #(.OSR_16384(15'd8), .OSR_2048(15'd4), .OSR_512(15'd2)) u_sdc_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .filter_result_i(res), .master_clk_en_o(mclk), .modulator_clk_en_o(mdc),
        .conv_done_o(done), .oversampling_select_o(osr),
        .neg_ref_buffer_enable_o(nbe), .neg_ref_bypass_o(nby),
        .pos_ref_buffer_enable_o(pbe), .pos_ref_bypass_o(pby),
        .reserved_trim_o(trim), .irq_o(irq));

    always #2 clk_i = ~clk_i;

    // Classic cycle; request held up to the edge that samples ack, data taken there
    task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we  <= w;
        adr <= {i, 2'b00};
        dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdv = rd[7:0];
        cyc <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        acc(1'b0, i, 8'h0);
        chk(rdv, e);
    endtask

    // Cycles between two pulses of the chosen strobe
    task automatic per(input int w);
        p = 0;
        do @(negedge clk_i); while (pl[w] !== 1'b1);
        do
        begin
            @(negedge clk_i);
            p++;
        end
        while (pl[w] !== 1'b1);
    endtask

    task automatic close_out();
        $display("Tests %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog: the tests need well under ten thousand cycles
    initial
    begin
        repeat (50000) @(posedge clk_i);
        n_fail++;
        close_out();
    end

    initial
    begin
        automatic int c[4] = '{0, 3, 30, 31};
        automatic int m[3] = '{0, 2, 5};
        automatic int o[4] = '{1, 4, 6, 9};
        automatic int r[4] = '{8, 4, 2, 4};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`SDC_IDX_CTRL_ONE, 8'h00);
        rdc(`SDC_IDX_SRC_DIV, 8'h00);
        rdc(`SDC_IDX_TRIM, 8'he4);
        rdc(`SDC_IDX_OSR_SEL, 8'h04);
        rdc(`SDC_IDX_IRQ_MASK, 8'h00);
        rdc(8'h3f, 8'h00);
        chk({nby, pby, osr, trim}, {2'b11, 4'h4, 8'he4});
        $display("Reset values done");
        acc(1'b1, `SDC_IDX_SRC_DIV, 8'hff);
        rdc(`SDC_IDX_SRC_DIV, 8'h1f);
        for (int k = 0; k < 2; k++)
        begin
            acc(1'b1, `SDC_IDX_CTRL_ONE, 8'h08 << k);
            chk({nbe, nby, pbe, pby}, k ? 4'b1001 : 4'b0110);
        end
        $display("Buffer controls done");
        acc(1'b1, `SDC_IDX_TRIM, 8'he7);
        rdc(`SDC_IDX_TRIM, 8'he7);
        chk(trim, 8'he7);
        acc(1'b1, `SDC_IDX_SRC_DIV, 8'h1f);
        foreach (c[k])
        begin
            acc(1'b1, `SDC_IDX_SRC_DIV, c[k][7:0]);
            per(0);
            per(0);
            chk(p, c[k] == 31 ? 1 : 2 * (c[k] + 1));
        end
        foreach (m[k])
        begin
            acc(1'b1, `SDC_IDX_CTRL_ONE, m[k][2:0] << 5);
            per(1);
            per(1);
            chk(p, m[k] == 2 ? 12 : 30);
        end
        foreach (o[k])
        begin
            acc(1'b1, `SDC_IDX_OSR_SEL, o[k][7:0]);
            chk(osr, o[k][3:0]);
            per(2);
            per(2);
            // Reserved modulator code 5 is still set, so N is 30 here
            chk(p, 30 * r[k]);
        end
        $display("Divider ratios done");
        per(2);
        rdc(`SDC_IDX_RESULT_LOW, 8'h56);
        rdc(`SDC_IDX_RESULT_MID, 8'h34);
        rdc(`SDC_IDX_RESULT_HIGH, 8'h12);
        acc(1'b1, `SDC_IDX_CTRL_ONE, 8'h44);
        res <= 24'habcdef;
        acc(1'b0, `SDC_IDX_IRQ_STATUS, 8'h0);
        per(2);
        rdc(`SDC_IDX_RESULT_LOW, 8'h56);
        rdc(`SDC_IDX_RESULT_HIGH, 8'h12);
        rdc(`SDC_IDX_CTRL_ONE, 8'h46);
        rdc(`SDC_IDX_IRQ_STATUS, 8'h03);
        rdc(`SDC_IDX_IRQ_STATUS, 8'h00);
        acc(1'b1, `SDC_IDX_CTRL_ONE, 8'h40);
        rdc(`SDC_IDX_CTRL_ONE, 8'h40);
        per(2);
        rdc(`SDC_IDX_RESULT_LOW, 8'hef);
        rdc(`SDC_IDX_RESULT_MID, 8'hcd);
        rdc(`SDC_IDX_RESULT_HIGH, 8'hab);
        $display("Result hold done");
        acc(1'b1, `SDC_IDX_IRQ_MASK, 8'h01);
        acc(1'b0, `SDC_IDX_IRQ_STATUS, 8'h0);
        per(2);
        chk(irq, 1'b1);
        acc(1'b0, `SDC_IDX_IRQ_STATUS, 8'h0);
        @(negedge clk_i);
        chk(irq, 1'b0);
        acc(1'b1, `SDC_IDX_IRQ_MASK, 8'h00);
        per(2);
        chk(irq, 1'b0);
        $display("Interrupt done");
        close_out();
    end
endmodule // tb_sdc_top
